//--- inc/lstm_pkg.sv
/*
  Constants and types for the line sensor trigger and mode controller.
  Assumes a 125 MHz core clock and a simple address/strobe register port.
*/
package lstm_pkg;
  // Clock and timing.
  localparam int CLK_NS = 8;
  localparam int US_NS = 1000;
  localparam int US_CYC = (US_NS + CLK_NS - 1) / CLK_NS;
  localparam int STRETCH_NS = 50;
  localparam int STRETCH_CYC = (STRETCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int TOUT_NS = 500;
  localparam int TOUT_CYC = (TOUT_NS + CLK_NS - 1) / CLK_NS;
  localparam int READOUT_US = 3710;
  localparam int SINGLE_MAX_US = 500;
  localparam int OFFS_MAX_US = 1849;
  // Register offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_INTEG = 8'h08;
  localparam logic [7:0] ADDR_OFFS = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  // Field positions.
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_CLR_BIT = 2;
  localparam int STAT_CAP_BIT = 0;
  localparam int STAT_SHUT_BIT = 1;
  localparam int STAT_REF_BIT = 2;
  localparam int STAT_TRIG_BIT = 3;
  localparam int STAT_INTEG_BIT = 4;
  localparam int STAT_RUN_BIT = 5;
  localparam int OFFS_W = 11;
  // Reset values.
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [31:0] INTEG_RST = 32'h0000000a;
  localparam logic [OFFS_W-1:0] OFFS_RST = 11'h000;

  typedef enum logic [2:0] {
    MODE_SW_START = 3'b000,
    MODE_HW_START = 3'b001,
    MODE_HW_ENABLE = 3'b010,
    MODE_SINGLE = 3'b011,
    MODE_EXT_SYNC = 3'b100
  } lstm_mode_t;

  typedef struct packed {
    logic dark_en;
    logic stream;
    lstm_mode_t mode;
  } lstm_ctrl_t;

  typedef struct packed {
    logic trig_out;
    logic integrating;
    logic sensor_clear;
    logic shutter;
    logic frame_done;
  } lstm_sens_t;
endpackage

//--- logic/lstm_core.sv
/*
  Trigger conditioning, frame timing and mode control for a line sensor.
  Assumes software drives the register port on clk and that trig_in is an
  asynchronous pin; frame storage and the host link sit elsewhere.
*/
// Our own choices: the plain strobed port and the address map.
// What this block does
// - Mode software-start runs frames from internal timing and captures after a start command.
// - Mode hardware-start runs frames from internal timing and captures after a trigger edge.
// - Mode hardware-enable runs frames from internal timing and captures while trigger is high.
// - Mode single keeps the sensor clear and takes one frame per trigger, only up to 500 us.
// - Mode external-sync times frames from trigger edges and captures after a start command.
// - Every mode works the same whether frames are stored onboard or streamed.
// - Trigger input acts on rising edges, or on its stretched level in hardware-enable, read per mode as start, enable, shot or sync.
// - Each trigger input pulse is lengthened by about 50 ns.
// - Outside external sync the trigger output rises when integration begins.
// - In external sync the trigger output rises when integration ends.
// - Each trigger output pulse is high for 500 ns.
// - In shutter mode, except single and external sync, the trigger output leads integration by a 0 to 1849 us offset, capped at the frame start.
// - Every setting is written at runtime and takes effect without a restart, except the mode, whose change restarts the frame timing.
// - Dark-level correction can be switched on at any moment.
// - Shutter mode is chosen when integration time is below 3710 us.
module lstm_core
  import lstm_pkg::*;
#(
  parameter int INT_W = 26
)
(
  // Clock, reset, enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  // Trigger pins.
  input wire logic trig_in,
  output logic trig_out,
  // Sensor and acquisition side.
  output logic integrating,
  output logic sensor_clear,
  output logic shutter_mode,
  output logic frame_done,
  output logic capturing,
  output logic stream_mode,
  output logic dark_en
);
  if (INT_W < 12 || INT_W > 31)
  begin : g_chk
    $error("INT_W must lie between 12 and 31");
  end
  function automatic logic [INT_W-1:0] sat_sub(input logic [INT_W-1:0] a,
                                               input logic [INT_W-1:0] b);
    sat_sub = (a > b) ? a - b : '0;
  endfunction
  localparam logic [INT_W-1:0] READOUT_W = INT_W'(READOUT_US);
  localparam logic [INT_W-1:0] SINGLE_W = INT_W'(SINGLE_MAX_US);
  localparam logic [6:0] US_LAST = 7'(US_CYC - 1);
  localparam logic [3:0] STRETCH_W = 4'(STRETCH_CYC);
  localparam logic [6:0] TOUT_W = 7'(TOUT_CYC);
  // Register group.
  lstm_ctrl_t ctrl_q, ctrl_d;
  logic [INT_W-1:0] integ_q, integ_d;
  logic [OFFS_W-1:0] offs_q, offs_d;
  logic refused_q, refused_d;
  logic [31:0] rdata_q, rdata_d;
  // Trigger input group.
  logic [2:0] sync_q, sync_d;
  logic lvl_q, lvl_d;
  logic [3:0] str_cnt_q, str_cnt_d;
  logic str_q, str_d;
  // Frame group.
  logic [6:0] pre_q, pre_d;
  logic run_q, run_d;
  logic [INT_W-1:0] fcnt_q, fcnt_d;
  logic cap_q, cap_d;
  logic integ_on_q, integ_on_d;
  logic done_q, done_d;
  logic [6:0] tout_cnt_q, tout_cnt_d;
  logic tout_q, tout_d;
  logic wr_ctrl, wr_cmd, mode_chg, cmd_start, cmd_stop;
  logic str_lvl, trig_edge, tick, shut;
  logic [INT_W-1:0] flen, istart, tstart;
  logic at_istart, at_end, fire;
  lstm_ctrl_t ctrl_new;
  assign ctrl_new = lstm_ctrl_t'(wdata[4:0]);
  assign wr_ctrl = wr_stb && addr == ADDR_CTRL;
  assign wr_cmd = wr_stb && addr == ADDR_CMD;
  assign mode_chg = wr_ctrl && ctrl_new.mode != ctrl_q.mode;
  assign cmd_start = wr_cmd && wdata[CMD_START_BIT];
  assign cmd_stop = wr_cmd && wdata[CMD_STOP_BIT];
  // Register file: writes take effect on the next cycle; only a mode change restarts frame timing.
  always_comb
  begin
    ctrl_d = ctrl_q;
    integ_d = integ_q;
    offs_d = offs_q;
    refused_d = refused_q;
    rdata_d = '0;
    if (wr_ctrl)
    begin
      ctrl_d = ctrl_new;
    end
    if (wr_stb && addr == ADDR_INTEG)
    begin
      integ_d = wdata[INT_W-1:0];
    end
    if (wr_stb && addr == ADDR_OFFS)
    begin
      offs_d = (wdata > 32'(OFFS_MAX_US)) ? OFFS_W'(OFFS_MAX_US) : wdata[OFFS_W-1:0];
    end
    if (wr_cmd && wdata[CMD_CLR_BIT])
    begin
      refused_d = 1'b0;
    end
    // A refused shot in the same cycle as a clear keeps the flag set.
    if (ctrl_q.mode == MODE_SINGLE && trig_edge && !run_q && integ_q > SINGLE_W)
    begin
      refused_d = 1'b1;
    end
    if (rd_stb)
    begin
      if (addr == ADDR_CTRL)
      begin
        rdata_d = {27'h0000000, ctrl_q};
      end
      else if (addr == ADDR_INTEG)
      begin
        rdata_d = 32'(integ_q);
      end
      else if (addr == ADDR_OFFS)
      begin
        rdata_d = 32'(offs_q);
      end
      else if (addr == ADDR_STAT)
      begin
        rdata_d[STAT_CAP_BIT] = cap_q;
        rdata_d[STAT_SHUT_BIT] = shut;
        rdata_d[STAT_REF_BIT] = refused_q;
        rdata_d[STAT_TRIG_BIT] = lvl_q;
        rdata_d[STAT_INTEG_BIT] = integ_on_q;
        rdata_d[STAT_RUN_BIT] = run_q;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= lstm_ctrl_t'(CTRL_RST);
      integ_q <= INTEG_RST[INT_W-1:0];
      offs_q <= OFFS_RST;
      refused_q <= 1'b0;
      rdata_q <= '0;
    end
    else if (ce)
    begin
      ctrl_q <= ctrl_d;
      integ_q <= integ_d;
      offs_q <= offs_d;
      refused_q <= refused_d;
      rdata_q <= rdata_d;
    end
  end

  // Trigger input: three-flop synchroniser, agreement filter, then stretch.
  assign str_lvl = lvl_q || str_cnt_q != 4'h0;
  assign trig_edge = str_lvl && !str_q;

  always_comb
  begin
    sync_d = {sync_q[1:0], trig_in};
    lvl_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
    str_cnt_d = str_cnt_q;
    if (lvl_d && !lvl_q)
    begin
      str_cnt_d = STRETCH_W;
    end
    else if (str_cnt_q != 4'h0 && !lvl_q)
    begin
      str_cnt_d = str_cnt_q - 4'h1;
    end
    str_d = str_lvl;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_q <= 3'h0;
      lvl_q <= 1'b0;
      str_cnt_q <= 4'h0;
      str_q <= 1'b0;
    end
    else if (ce)
    begin
      sync_q <= sync_d;
      lvl_q <= lvl_d;
      str_cnt_q <= str_cnt_d;
      str_q <= str_d;
    end
  end

  // Frame geometry, all in microseconds.
  assign shut = integ_q < READOUT_W;
  assign tick = pre_q == US_LAST;
  assign flen = (shut && ctrl_q.mode != MODE_SINGLE) ? READOUT_W : integ_q;
  assign istart = sat_sub(flen, integ_q);
  assign tstart = shut ? sat_sub(istart, INT_W'(offs_q)) : istart;
  assign at_istart = run_q && tick && fcnt_q == istart;
  assign at_end = run_q && tick && fcnt_q == flen - INT_W'(1);
  assign fire = (ctrl_q.mode == MODE_EXT_SYNC) ? at_end
              : run_q && tick && fcnt_q == tstart;

  always_comb
  begin
    pre_d = tick ? 7'h00 : pre_q + 7'h01;
    run_d = run_q;
    fcnt_d = fcnt_q;
    cap_d = cap_q;
    integ_on_d = integ_on_q;
    done_d = at_end && cap_q;
    tout_cnt_d = (tout_cnt_q != 7'h00) ? tout_cnt_q - 7'h01 : 7'h00;
    if (fire)
    begin
      tout_cnt_d = TOUT_W;
    end
    tout_d = tout_cnt_d != 7'h00;
    if (at_istart)
    begin
      integ_on_d = 1'b1;
    end
    if (tick && run_q)
    begin
      fcnt_d = fcnt_q + INT_W'(1);
    end
    if (at_end)
    begin
      integ_on_d = 1'b0;
      fcnt_d = '0;
      if (ctrl_q.mode == MODE_SINGLE || ctrl_q.mode == MODE_EXT_SYNC)
      begin
        run_d = 1'b0;
      end
    end
    case (ctrl_q.mode)
      MODE_SW_START:
      begin
        run_d = 1'b1;
        cap_d = cmd_start || (cap_q && !cmd_stop);
      end
      MODE_HW_START:
      begin
        run_d = 1'b1;
        cap_d = trig_edge || (cap_q && !cmd_stop);
      end
      MODE_HW_ENABLE:
      begin
        run_d = 1'b1;
        cap_d = str_lvl;
      end
      MODE_SINGLE:
      begin
        if (trig_edge && !run_q && integ_q <= SINGLE_W)
        begin
          run_d = 1'b1;
          fcnt_d = '0;
          pre_d = 7'h00;
        end
        cap_d = run_d;
      end
      MODE_EXT_SYNC:
      begin
        if (trig_edge)
        begin
          run_d = 1'b1;
          fcnt_d = '0;
          pre_d = 7'h00;
          integ_on_d = 1'b0;
        end
        cap_d = cmd_start || (cap_q && !cmd_stop);
      end
      default:
      begin
        run_d = 1'b0;
        cap_d = 1'b0;
      end
    endcase
    // A new mode restarts the frame timing at once.
    if (mode_chg)
    begin
      run_d = 1'b0;
      fcnt_d = '0;
      cap_d = 1'b0;
      integ_on_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_q <= 7'h00;
      run_q <= 1'b0;
      fcnt_q <= '0;
      cap_q <= 1'b0;
      integ_on_q <= 1'b0;
      done_q <= 1'b0;
      tout_cnt_q <= 7'h00;
      tout_q <= 1'b0;
    end
    else if (ce)
    begin
      pre_q <= pre_d;
      run_q <= run_d;
      fcnt_q <= fcnt_d;
      cap_q <= cap_d;
      integ_on_q <= integ_on_d;
      done_q <= done_d;
      tout_cnt_q <= tout_cnt_d;
      tout_q <= tout_d;
    end
  end

  assign rdata = rdata_q;
  assign trig_out = tout_q;
  assign integrating = integ_on_q;
  assign sensor_clear = ctrl_q.mode == MODE_SINGLE && !run_q;
  assign shutter_mode = shut;
  assign frame_done = done_q;
  assign capturing = cap_q;
  assign stream_mode = ctrl_q.stream;
  assign dark_en = ctrl_q.dark_en;

endmodule // lstm_core

//--- dv/lstm_core_sva.sv
/*
  Port checker for the line sensor trigger and mode controller.
  Assumes one clock domain and that ce stays high while checked.
*/
module lstm_core_sva
  import lstm_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rdata,
  // Sensor side.
  input wire logic trig_out,
  input wire logic integrating,
  input wire logic sensor_clear,
  input wire logic shutter_mode,
  input wire logic frame_done,
  input wire logic capturing,
  input wire logic stream_mode,
  input wire logic dark_en
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  lstm_mode_t mode_q;
  lstm_mode_t mode_d;
  logic [6:0] hi_q;
  logic [6:0] hi_d;
  logic wr_ctrl;
  logic wr_cmd;
  assign wr_ctrl = ce && wr_stb && addr == ADDR_CTRL;
  assign wr_cmd = ce && wr_stb && addr == ADDR_CMD;
  // Tracks the mode written and how long the trigger output has stood high.
  always_comb
  begin
    mode_d = wr_ctrl ? lstm_mode_t'(wdata[2:0]) : mode_q;
    hi_d = trig_out ? hi_q + 7'h01 : 7'h00;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= MODE_SW_START;
      hi_q <= 7'h00;
    end
    else
    begin
      mode_q <= mode_d;
      hi_q <= hi_d;
    end
  end
  chk_rdata_idle: assert property ($past(ce) && !$past(rd_stb) |-> rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  chk_out_width: assert property ($fell(trig_out) |-> hi_q == 7'(TOUT_CYC))
    else $error("trigger output pulse of wrong width");
  chk_out_max: assert property (trig_out |-> hi_q < 7'(TOUT_CYC))
    else $error("trigger output held too long");
  chk_done_pulse: assert property (frame_done |=> !frame_done)
    else $error("frame end longer than one cycle");
  chk_clear_idle: assert property (sensor_clear |-> !integrating)
    else $error("sensor cleared while integrating");
  chk_clear_mode: assert property (wr_ctrl && wdata[2:0] != 3'h3 |=> !sensor_clear)
    else $error("sensor clear outside single mode");
  chk_stream_bit: assert property (wr_ctrl |=> stream_mode == $past(wdata[3]))
    else $error("stream mode not applied");
  chk_dark_bit: assert property (wr_ctrl |=> dark_en == $past(wdata[4]))
    else $error("dark correction enable not applied");
  chk_shutter_set: assert property (ce && wr_stb && addr == ADDR_INTEG |=>
    shutter_mode == ($past(wdata) < READOUT_US))
    else $error("shutter mode choice wrong");
  chk_sw_start: assert property (mode_q == MODE_SW_START && wr_cmd && wdata[1:0] == 2'h1
    |-> ##[1:4] capturing)
    else $error("capture start command not obeyed");
endmodule // lstm_core_sva

bind lstm_core lstm_core_sva u_sva (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .trig_out(trig_out),
  .integrating(integrating), .sensor_clear(sensor_clear), .shutter_mode(shutter_mode),
  .frame_done(frame_done), .capturing(capturing), .stream_mode(stream_mode),
  .dark_en(dark_en));

//--- dv/lstm_trig_model.sv
/*
  External trigger instrument driving the controller's trigger input.
  Assumes the controller samples the pin with no timing relation to it.
*/
module lstm_trig_model
(
  // Trigger pin driven by the instrument.
  output logic trig_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial trig_in = 1'b0;
  // Pulses start off the clock edge and may be shorter than a clock period.
  task automatic fire(input int width_ns);
    #3 trig_in = 1'b1;
    #(width_ns) trig_in = 1'b0;
  endtask
endmodule // lstm_trig_model

//--- dv/lstm_core_test.sv
/*
  Self-checking testbench for the line sensor trigger and mode controller.
  Assumes the checker is bound to lstm_core and a trigger instrument model.
*/
module lstm_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  import lstm_pkg::*;
  logic clk, rst_n, ce, wr_stb, rd_stb, trig_in, trig_out, integrating, sensor_clear;
  logic shutter_mode, frame_done, capturing, stream_mode, dark_en;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  int mismatches, compares, n;
  lstm_core DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .trig_in(trig_in), .trig_out(trig_out),
    .integrating(integrating), .sensor_clear(sensor_clear), .shutter_mode(shutter_mode),
    .frame_done(frame_done), .capturing(capturing), .stream_mode(stream_mode),
    .dark_en(dark_en));
  lstm_trig_model u_trig (.trig_in(trig_in));
  always #4 clk = ~clk;

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return integrating;
      1: return trig_out;
      default: return capturing;
    endcase
  endfunction
  // Waits until the chosen output takes a level; running out is a failure.
  task automatic wait_sig(input int s, input logic lvl, input int lim);
    int k;
    k = 0;
    while (sig(s) !== lvl && k < lim)
    begin
      @(posedge clk);
      #1 k++;
    end
    check("output level after wait", sig(s), lvl);
    if (sig(s) !== lvl)
      test_done();
  endtask

  task automatic t_reset();
    rd(ADDR_CTRL, v);
    check("ctrl reset", v, {27'h0, CTRL_RST});
    rd(ADDR_INTEG, v);
    check("integration_time reset", v, INTEG_RST);
    rd(8'h20, v);
    check("unmapped read", v, 32'h0);
    check("shutter after reset", shutter_mode, 32'h1);
  endtask
  task automatic t_ctrl();
    wr(ADDR_CTRL, 32'h18);
    check("stream on", stream_mode, 32'h1);
    check("dark on", dark_en, 32'h1);
    rd(ADDR_CTRL, v);
    check("ctrl readback", v, 32'h18);
    // A write while the clock enable is low must leave every setting as it was.
    @(posedge clk);
    ce <= 1'b0;
    wr(ADDR_CTRL, 32'h0);
    check("frozen while disabled", stream_mode, 32'h1);
    @(posedge clk);
    ce <= 1'b1;
    wr(ADDR_CTRL, 32'h0);
    check("stream off", stream_mode, 32'h0);
  endtask
  task automatic t_shutter();
    wr(ADDR_INTEG, 32'(READOUT_US - 1));
    check("shutter below limit", shutter_mode, 32'h1);
    wr(ADDR_INTEG, 32'(READOUT_US));
    check("no shutter at limit", shutter_mode, 32'h0);
    wr(ADDR_INTEG, 32'ha);
    wr(ADDR_OFFS, 32'h7d0);
    rd(ADDR_OFFS, v);
    check("offset clamped", v, 32'(OFFS_MAX_US));
    wr(ADDR_OFFS, 32'h5);
    rd(ADDR_OFFS, v);
    check("offset readback", v, 32'h5);
  endtask
  task automatic t_modes();
    wr(ADDR_CMD, 32'h1);
    wait_sig(2, 1'b1, 8);
    wr(ADDR_CMD, 32'h2);
    wait_sig(2, 1'b0, 8);
    wr(ADDR_CTRL, 32'h1);
    check("no capture before edge", capturing, 32'h0);
    // Pulses span at least two clocks so that two synchroniser stages agree.
    u_trig.fire(24);
    wait_sig(2, 1'b1, 20);
    wr(ADDR_CTRL, 32'h2);
    fork
      u_trig.fire(2000);
      wait_sig(2, 1'b1, 20);
    join
    repeat (8) @(posedge clk);
    #1 check("stretched enable", capturing, 32'h1);
    wait_sig(2, 1'b0, 20);
  endtask
  task automatic t_single();
    wr(ADDR_CTRL, 32'h3);
    check("sensor kept clear", sensor_clear, 32'h1);
    u_trig.fire(24);
    wait_sig(1, 1'b1, 300);
    wait_sig(0, 1'b1, 3);
    n = 0;
    while (trig_out === 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1 n++;
    end
    check("trigger output width", n, TOUT_CYC);
    wait_sig(0, 1'b0, 1400);
    check("frame end pulse", frame_done, 32'h1);
    wr(ADDR_INTEG, 32'(SINGLE_MAX_US + 1));
    u_trig.fire(24);
    repeat (100) @(posedge clk);
    #1 check("long shot refused", integrating, 32'h0);
    rd(ADDR_STAT, v);
    check("refused flag", v[STAT_REF_BIT], 32'h1);
    wr(ADDR_CMD, 32'h4);
    rd(ADDR_STAT, v);
    check("refused flag cleared", v[STAT_REF_BIT], 32'h0);
  endtask
  task automatic t_sync();
    wr(ADDR_CTRL, 32'h4);
    u_trig.fire(24);
    repeat (20) @(posedge clk);
    #1 check("no output at frame start", trig_out, 32'h0);
    check("no capture before command", capturing, 32'h0);
    rd(ADDR_STAT, v);
    check("frame started by trigger", v[STAT_RUN_BIT], 32'h1);
    wr(ADDR_CMD, 32'h1);
    check("capture after command", capturing, 32'h1);
    // Codes above the last mode leave the frame timing idle.
    wr(ADDR_CTRL, 32'h5);
    rd(ADDR_STAT, v);
    check("unused mode stopped", v[STAT_RUN_BIT], 32'h0);
    check("unused mode no capture", capturing, 32'h0);
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    mismatches = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_ctrl();
    t_shutter();
    t_modes();
    t_single();
    t_sync();
    test_done();
  end
endmodule // lstm_core_test
